// file: rtl/sams_pkg.sv
// constants and types for the serial converter sequencer
// assumes one 200 MHz system clock; serial pins are asynchronous to it
package sams_pkg;
	// address shift register: start bit plus assignment word
	localparam int ADDR_W = 5;
	localparam int START_POS8 = 4;
	localparam int START_POS4 = 3;
	// field positions below the start bit, eight-input layout
	localparam int F8_SINGLE = 3;
	localparam int F8_POL = 2;
	localparam int F8_HI = 1;
	localparam int F8_LO = 0;
	// field positions, four-input layout
	localparam int F4_SINGLE = 2;
	localparam int F4_POL = 1;
	localparam int F4_HI = 0;
	// result and output register widths
	localparam int RES_W = 8;
	localparam int SR_W = 9;
	localparam logic [2:0] MSB_IDX = 3'h7;
	localparam logic [3:0] CONV_BITS = 4'h8;
	// result buffer shape
	localparam int FIFO_W = 8;
	localparam int FIFO_D = 32;
	// sequencer states, gray along the usual path
	typedef enum logic [2:0] {
		ST_ADDR = 3'h0,
		ST_HOLD = 3'h1,
		ST_SETTLE = 3'h3,
		ST_CONV = 3'h2,
		ST_TAIL = 3'h6
	} sams_state_t;
endpackage : sams_pkg

// file: rtl/sams_fifo.sv
// result buffer: show-ahead fifo with a registered output stage
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ps
module sams_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// filling side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// draining side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW:0] cnt;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic ov;
		logic [WIDTH-1:0] od;
	} sams_fifo_st_t;
	sams_fifo_st_t st_reg, st_next;
	logic [WIDTH-1:0] mem [DEPTH]; // storage kept out of the struct
	logic wr, rd;
	// full is honest: the output stage is not counted as room
	assign in_ready = st_reg.cnt != (AW+1)'(DEPTH);
	assign wr = in_valid && in_ready;
	assign rd = (st_reg.cnt != '0) && (!st_reg.ov || out_ready);
	assign out_valid = st_reg.ov;
	assign out_data = st_reg.od;
	// pointer, count and output stage update
	always_comb begin
		st_next = st_reg;
		if (out_ready && st_reg.ov) begin
			st_next.ov = 1'b0;
		end
		if (wr) begin
			st_next.wp = st_reg.wp + 1'b1;
		end
		if (rd) begin
			st_next.od = mem[st_reg.rp];
			st_next.ov = 1'b1;
			st_next.rp = st_reg.rp + 1'b1;
		end
		st_next.cnt = st_reg.cnt + (AW+1)'(wr) - (AW+1)'(rd);
	end
	// register the state and write the array
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
		if (wr) begin
			mem[st_reg.wp] <= in_data;
		end
	end
endmodule : sams_fifo

// file: rtl/sams_top.sv
// serial control of an 8-bit successive-approximation converter
// assumes the serial pins and the comparator are asynchronous to clk,
// and the serial clock is far slower than clk
`timescale 1ns/1ps
module sams_top #(
	parameter bit EIGHT_INPUT = 1'b1 // 0 selects the four-input variant
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// serial link pins from the controller
	input wire logic conv_select_n,
	input wire logic conv_clk,
	input wire logic serial_addr_in,
	input wire logic lsb_first_enable_n,
	// serial result pin, data and enable of a tristate, plus busy
	output logic serial_result_out,
	output logic serial_result_oe,
	output logic conversion_active,
	// analog side: ladder code, comparator, mux selection
	output logic [7:0] ladder_code,
	input wire logic cmp_above,
	output logic mux_enable,
	output logic [2:0] mux_pos_ch,
	output logic [2:0] mux_neg_ch,
	output logic mux_neg_common,
	output logic mux_neg_ground,
	// finished results
	output logic result_valid,
	output logic [7:0] result_data,
	input wire logic result_ready
);
	// all state of the sequencer
	typedef struct packed {
		logic cs_m; // synchroniser first stages
		logic cs_s;
		logic ck_m;
		logic ck_s;
		logic ck_d; // delayed copy for edge detect
		logic di_m;
		logic di_s;
		logic se_m;
		logic se_s;
		logic cmp_m;
		logic cmp_s;
		sams_pkg::sams_state_t st;
		logic [sams_pkg::ADDR_W-1:0] addr;
		logic single;
		logic pol;
		logic hi;
		logic lo;
		logic settled;
		logic [2:0] idx; // bit being decided
		logic [3:0] nbits; // decisions made this conversion
		logic [sams_pkg::RES_W-1:0] res;
		logic [sams_pkg::RES_W-1:0] trial;
		logic [sams_pkg::SR_W-1:0] sr;
		logic dout;
		logic oe;
		logic active;
		logic push;
		logic mux_en;
		logic [2:0] pos;
		logic [2:0] neg;
		logic neg_com;
		logic neg_gnd;
	} sams_top_st_t;

	sams_top_st_t st_reg, st_next;
	logic rise; // one-cycle enable on rising serial clock
	logic fall; // one-cycle enable on falling serial clock
	logic fifo_rdy; // buffer has room for one more result
	logic [sams_pkg::ADDR_W-1:0] a_nx; // address after this shift
	logic start_hit;

	// trial code: decided bits kept, bit under test set
	function automatic logic [7:0] sams_trial(input logic [7:0] res, input logic [2:0] idx);
		logic [7:0] t;
		t = res;
		t[idx] = 1'b1;
		return t;
	endfunction : sams_trial

	// edges come from the second stage and its delayed copy only
	assign rise = st_reg.ck_s && !st_reg.ck_d;
	assign fall = !st_reg.ck_s && st_reg.ck_d;
	assign a_nx = {st_reg.addr[sams_pkg::ADDR_W-2:0], st_reg.di_s};
	// start bit has reached the start location
	assign start_hit = EIGHT_INPUT ? a_nx[sams_pkg::START_POS8]
		: a_nx[sams_pkg::START_POS4];

	// next-state logic
	always_comb begin
		st_next = st_reg;
		st_next.push = 1'b0;
		// two flip-flops on every asynchronous input
		st_next.cs_m = conv_select_n;
		st_next.cs_s = st_reg.cs_m;
		st_next.ck_m = conv_clk;
		st_next.ck_s = st_reg.ck_m;
		st_next.ck_d = st_reg.ck_s;
		st_next.di_m = serial_addr_in;
		st_next.di_s = st_reg.di_m;
		st_next.se_m = lsb_first_enable_n;
		st_next.se_s = st_reg.se_m;
		st_next.cmp_m = cmp_above;
		st_next.cmp_s = st_reg.cmp_m;
		if (st_reg.cs_s) begin
			// deselected: clear everything, release the pin
			st_next.st = sams_pkg::ST_ADDR;
			st_next.addr = '0;
			st_next.sr = '0;
			st_next.res = '0;
			st_next.trial = '0;
			st_next.single = 1'b0;
			st_next.pol = 1'b0;
			st_next.hi = 1'b0;
			st_next.lo = 1'b0;
			st_next.settled = 1'b0;
			st_next.idx = '0;
			st_next.nbits = '0;
			st_next.dout = 1'b0;
			st_next.oe = 1'b0;
			st_next.active = 1'b0;
			st_next.mux_en = 1'b0;
			st_next.pos = '0;
			st_next.neg = '0;
			st_next.neg_com = 1'b0;
			st_next.neg_gnd = 1'b0;
		end else begin
			// selected: logic enabled
			unique case (st_reg.st)
				sams_pkg::ST_ADDR: begin
					// pin is undriven here, so a shared wire is safe
					if (rise) begin
						st_next.addr = a_nx;
						if (start_hit) begin
							// capture the word in shift order
							if (EIGHT_INPUT) begin
								st_next.single = a_nx[sams_pkg::F8_SINGLE];
								st_next.pol = a_nx[sams_pkg::F8_POL];
								st_next.hi = a_nx[sams_pkg::F8_HI];
								st_next.lo = a_nx[sams_pkg::F8_LO];
							end else begin
								st_next.single = a_nx[sams_pkg::F4_SINGLE];
								st_next.pol = a_nx[sams_pkg::F4_POL];
								st_next.hi = a_nx[sams_pkg::F4_HI];
								st_next.lo = 1'b1;
							end
							st_next.st = sams_pkg::ST_HOLD;
						end
					end
				end
				sams_pkg::ST_HOLD: begin
					// waits only while the result buffer is full
					if (fifo_rdy) begin
						st_next.active = 1'b1;
						st_next.mux_en = 1'b1;
						st_next.st = sams_pkg::ST_SETTLE;
						if (st_reg.single) begin
							// single-ended: one channel against a fixed negative
							st_next.pos = EIGHT_INPUT ? {st_reg.hi, st_reg.lo, st_reg.pol}
								: {1'b0, st_reg.hi, st_reg.pol};
							st_next.neg = '0;
							st_next.neg_com = EIGHT_INPUT;
							st_next.neg_gnd = !EIGHT_INPUT;
						end else begin
							// differential: both members of one pair only
							st_next.pos = EIGHT_INPUT ? {st_reg.hi, st_reg.lo, st_reg.pol}
								: {1'b0, st_reg.hi, st_reg.pol};
							st_next.neg = EIGHT_INPUT ? {st_reg.hi, st_reg.lo, !st_reg.pol}
								: {1'b0, st_reg.hi, !st_reg.pol};
							st_next.neg_com = 1'b0;
							st_next.neg_gnd = 1'b0;
						end
					end
				end
				sams_pkg::ST_SETTLE: begin
					// one serial clock period lets the mux settle
					if (fall && !st_reg.settled) begin
						st_next.oe = 1'b1;
						st_next.dout = 1'b0;
						st_next.settled = 1'b1;
					end else if (rise && st_reg.settled) begin
						st_next.idx = sams_pkg::MSB_IDX;
						st_next.trial = sams_trial('0, sams_pkg::MSB_IDX);
						st_next.st = sams_pkg::ST_CONV;
					end
				end
				sams_pkg::ST_CONV: begin
					if (rise) begin
						// new trial on the rising edge, decided on the falling one
						st_next.trial = sams_trial(st_reg.res, st_reg.idx);
					end else if (fall) begin
						// a negative input never beats the ladder, so bits stay zero
						st_next.res[st_reg.idx] = st_reg.cmp_s;
						st_next.dout = st_reg.cmp_s;
						st_next.nbits = st_reg.nbits + 4'h1;
						if (st_reg.idx == 3'h0) begin
							st_next.sr = {1'b0, st_reg.res[7:1], st_reg.cmp_s};
							st_next.push = 1'b1;
							st_next.st = sams_pkg::ST_TAIL;
						end else begin
							st_next.idx = st_reg.idx - 3'h1;
						end
					end
				end
				sams_pkg::ST_TAIL: begin
					// busy ends at the rise after the last decision
					if (rise && st_reg.active) begin
						st_next.active = 1'b0;
						st_next.mux_en = 1'b0;
					end
					// four-input always shifts; eight-input waits for the enable
					if (fall && (!EIGHT_INPUT || !st_reg.se_s)) begin
						st_next.sr = {1'b0, st_reg.sr[sams_pkg::SR_W-1:1]};
						st_next.dout = st_reg.sr[1];
					end // otherwise the LSB stays on the line
				end
				default: begin
					st_next.st = sams_pkg::ST_ADDR;
				end
			endcase
		end
	end

	// one register stage for the whole state
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_reg <= '0;
			st_reg.cs_m <= 1'b1;
			st_reg.cs_s <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// results are buffered so a slow reader never loses one
	sams_fifo #(
		.WIDTH(sams_pkg::FIFO_W),
		.DEPTH(sams_pkg::FIFO_D)
	) u_fifo (
		.clk(clk),
		.sys_rst(sys_rst),
		.in_valid(st_reg.push),
		.in_data(st_reg.res),
		.in_ready(fifo_rdy),
		.out_valid(result_valid),
		.out_data(result_data),
		.out_ready(result_ready)
	);

	// every output straight from the state register
	assign serial_result_out = st_reg.dout;
	assign serial_result_oe = st_reg.oe;
	assign conversion_active = st_reg.active;
	assign ladder_code = st_reg.trial;
	assign mux_enable = st_reg.mux_en;
	assign mux_pos_ch = st_reg.pos;
	assign mux_neg_ch = st_reg.neg;
	assign mux_neg_common = st_reg.neg_com;
	assign mux_neg_ground = st_reg.neg_gnd;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_desel_release: assert property (st_reg.cs_s |=> !serial_result_oe && !conversion_active)
		else $error("pin still driven after deselect");
	a_desel_clear: assert property (st_reg.cs_s |=> st_reg.addr == '0 && st_reg.sr == '0
		&& st_reg.st == sams_pkg::ST_ADDR)
		else $error("state not cleared after deselect");
	a_addr_undriven: assert property (st_reg.st == sams_pkg::ST_ADDR |-> !serial_result_oe)
		else $error("output driven during addressing");
	a_start_launch: assert property (!st_reg.cs_s && st_reg.st == sams_pkg::ST_ADDR && rise && start_hit
		|=> st_reg.st == sams_pkg::ST_HOLD ##1 !fifo_rdy || conversion_active)
		else $error("start bit did not launch conversion");
	a_addr_frozen: assert property (!st_reg.cs_s && st_reg.st != sams_pkg::ST_ADDR
		&& !st_next.cs_s |=> $stable(st_reg.addr))
		else $error("address shifted during conversion");
	a_settle_low: assert property (st_reg.st == sams_pkg::ST_SETTLE && serial_result_oe
		|-> !serial_result_out)
		else $error("settling bit not low");
	a_msb_trial: assert property (!st_reg.cs_s && st_reg.st == sams_pkg::ST_SETTLE && st_reg.settled && rise
		|=> ladder_code == 8'h80)
		else $error("first trial not the MSB");
	a_eight_bits: assert property ($rose(st_reg.st == sams_pkg::ST_TAIL)
		|-> st_reg.nbits == sams_pkg::CONV_BITS)
		else $error("conversion did not take eight bits");
	a_lsb_hold: assert property (EIGHT_INPUT && !st_reg.cs_s && st_reg.st == sams_pkg::ST_TAIL
		&& st_reg.se_s && fall |=> $stable(serial_result_out))
		else $error("lsb not held with enable high");
	a_pair_bound: assert property (mux_enable && !mux_neg_common && !mux_neg_ground
		|-> mux_pos_ch[2:1] == mux_neg_ch[2:1] && mux_pos_ch[0] != mux_neg_ch[0])
		else $error("differential pair crossed");

	// busy and the channel come up together, straight into settling
	a_busy_rise: assert property ($rose(conversion_active)
		|-> mux_enable && st_reg.st == sams_pkg::ST_SETTLE)
		else $error("busy rose without a selected channel");

	// a full buffer parks the start: no busy, pin still released
	a_hold_quiet: assert property (st_reg.st == sams_pkg::ST_HOLD
		|-> !conversion_active && !serial_result_oe)
		else $error("waiting start is not quiet");

	// the pin is only ever taken during settling
	a_oe_settle: assert property ($rose(serial_result_oe)
		|-> st_reg.st == sams_pkg::ST_SETTLE && !serial_result_out)
		else $error("pin driven outside settling");

	// each decision goes to the pin at the fall that makes it
	a_bit_out: assert property (!st_reg.cs_s && st_reg.st == sams_pkg::ST_CONV && fall
		|=> serial_result_out == $past(st_reg.cmp_s))
		else $error("decided bit not on the pin");

	// busy drops only after the last decision, unless deselected
	a_busy_drop: assert property ($fell(conversion_active) && !$past(st_reg.cs_s)
		|-> st_reg.st == sams_pkg::ST_TAIL)
		else $error("busy dropped before eight bits");

	// a low enable walks the output register one place per fall
	a_tail_shift: assert property (!st_reg.cs_s && st_reg.st == sams_pkg::ST_TAIL && fall && !st_reg.se_s
		|=> serial_result_out == $past(st_reg.sr[1]))
		else $error("lsb-first copy not shifted");

	// a single-ended negative is either the common input or ground, never both
	a_single_neg: assert property (mux_neg_common |-> !mux_neg_ground)
		else $error("two fixed negatives at once");

	// a trial always carries the bit under test
	a_trial_bit: assert property (!st_reg.cs_s && st_reg.st == sams_pkg::ST_CONV && rise
		|=> ladder_code[$past(st_reg.idx)])
		else $error("trial bit not set");

	// main scenarios worth seeing: full runs, lsb-first copy, stalls, modes, aborts
	// an abort is a deselect while busy; before the last decision the buffer does not see it
	c_conv_done: cover property ($rose(st_reg.st == sams_pkg::ST_TAIL));
	c_lsb_shift: cover property (st_reg.st == sams_pkg::ST_TAIL && fall && !st_reg.se_s);
	c_buffer_full: cover property (st_reg.st == sams_pkg::ST_HOLD && !fifo_rdy);
	c_single_end: cover property (mux_enable && (mux_neg_common || mux_neg_ground));
	c_abort: cover property ($fell(conversion_active) && st_reg.st == sams_pkg::ST_ADDR);
endmodule : sams_top

// file: tb/sams_ctrl_model.sv
// controller model: drives select, serial clock and address, samples the result
// assumes clk paces the serial clock at sixteen clk per serial period
`timescale 1ns/1ps
module sams_ctrl_model (
	// pacing clock
	input wire logic clk,
	// serial pins driven by the controller
	output logic conv_select_n,
	output logic conv_clk,
	output logic lsb_first_enable_n,
	output logic line_drive,
	output logic line_bit,
	// shared wire as the controller sees it
	input wire logic line_level,
	input wire logic serial_result_oe
);
	// idle: deselected, serial clock parked low, wire released
	initial begin
		conv_select_n = 1'b1;
		conv_clk = 1'b0;
		lsb_first_enable_n = 1'b1;
		line_drive = 1'b0;
		line_bit = 1'b0;
	end

	// one serial clock level, eight clk long, changed just after a clk edge
	task automatic half(input logic lvl);
		conv_clk = lvl;
		repeat (8) @(posedge clk);
		#1;
	endtask : half

	// one frame: a leading zero, start bit and word, then n samples at rises
	task automatic run(input logic [4:0] addr, input int hold, input int n, output logic [31:0] got,
		output logic [31:0] drv);
		logic [5:0] seq;
		seq = {1'b0, addr};
		got = '0;
		drv = '0;
		conv_select_n = 1'b0;
		repeat (6) @(posedge clk);
		#1;
		line_drive = 1'b1;
		for (int i = 5; i >= 0; i--) begin
			line_bit = seq[i];
			half(1'b1);
			// let go of the wire before the device starts driving it
			line_drive = (i != 0);
			half(1'b0);
		end
		for (int k = 0; k < n; k++) begin
			got[k] = line_level;
			drv[k] = serial_result_oe;
			half(1'b1);
			// lsb-first only after the held bits, changed in the same instant as the fall
			if (k == 8 + hold) lsb_first_enable_n = 1'b0;
			half(1'b0);
		end
		// select held low for the whole frame, raised only here
		conv_select_n = 1'b1;
		lsb_first_enable_n = 1'b1;
		repeat (6) @(posedge clk);
		#1;
	endtask : run
endmodule : sams_ctrl_model

// file: tb/sams_top_tb_top.sv
// testbench for the serial converter sequencer, eight-input variant
// assumes the design files and the controller model are compiled first
`timescale 1ns/1ps
module sams_top_tb_top;
	// about twice what the sequence below needs
	localparam int TIMEOUT_CYCLES = 40000;
	// clock, reset and counters
	logic clk = 1'b0;
	logic sys_rst;
	int errors = 0;
	int num_checks = 0;
	int cycles = 0;
	// serial pins and the shared data wire
	logic conv_select_n, conv_clk, lsb_first_enable_n, line_drive, line_bit;
	logic float_bit = 1'b0;
	wire logic line_level;
	// design outputs and the remaining inputs
	logic serial_result_out, serial_result_oe, conversion_active, cmp_above, mux_enable;
	logic mux_neg_common, mux_neg_ground, result_valid, result_ready;
	logic [7:0] ladder_code, result_data;
	logic [2:0] mux_pos_ch, mux_neg_ch;
	// analog levels in ladder steps; several pairs go negative on purpose
	logic [7:0] ana [8] = '{8'hC3, 8'h5A, 8'h10, 8'hF0, 8'h80, 8'h7F, 8'h01, 8'hFF};
	logic [7:0] com_lvl = 8'h40;
	int neg_v;
	int diff;
	// captured during conversion and from the result stream
	logic [2:0] cap_p, cap_n;
	logic cap_cm, cap_gnd;
	int busy_cnt = 0;
	int busy_len = 0;
	logic [7:0] pop_q [$];
	logic [7:0] exp_q [$];

	always #2.5 clk = ~clk;

	// wire level: device when enabled, else controller, else a line that never rests
	assign line_level = serial_result_oe ? serial_result_out : line_drive ? line_bit : float_bit;

	// comparator: a half-step offset makes the code equal the difference, floored at zero
	always_comb begin
		neg_v = mux_neg_common ? int'(com_lvl) : mux_neg_ground ? 0 : int'(ana[mux_neg_ch]);
		diff = int'(ana[mux_pos_ch]) - neg_v;
		cmp_above = mux_enable && (diff >= int'(ladder_code));
	end

	sams_top #(.EIGHT_INPUT(1'b1)) dut (
		.clk(clk), .sys_rst(sys_rst), .conv_select_n(conv_select_n), .conv_clk(conv_clk),
		.serial_addr_in(line_level), .lsb_first_enable_n(lsb_first_enable_n),
		.serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe),
		.conversion_active(conversion_active), .ladder_code(ladder_code), .cmp_above(cmp_above),
		.mux_enable(mux_enable), .mux_pos_ch(mux_pos_ch), .mux_neg_ch(mux_neg_ch),
		.mux_neg_common(mux_neg_common), .mux_neg_ground(mux_neg_ground),
		.result_valid(result_valid), .result_data(result_data), .result_ready(result_ready)
	);

	sams_ctrl_model ctl (
		.clk(clk), .conv_select_n(conv_select_n), .conv_clk(conv_clk),
		.lsb_first_enable_n(lsb_first_enable_n), .line_drive(line_drive), .line_bit(line_bit),
		.line_level(line_level), .serial_result_oe(serial_result_oe)
	);

	// one comparison, counted; mismatches reported at once
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	// verdict and end of run
	task automatic finish_test;
		if (errors == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : finish_test

	// channels from the word; positive is always the pair member named by polarity
	function automatic logic [7:0] expect_conv(input logic [3:0] c, output logic [2:0] p,
		output logic [2:0] n, output logic cm);
		int d;
		cm = c[3];
		p = {c[1], c[0], c[2]};
		n = {c[1], c[0], ~c[2]};
		d = int'(ana[p]) - (cm ? int'(com_lvl) : int'(ana[n]));
		return (d < 0) ? 8'h00 : d[7:0];
	endfunction : expect_conv

	// samples per rise: settle low, msb first, held lsb, lsb-first copy, then zeros
	function automatic logic [31:0] expect_stream(input logic [7:0] r, input int h, input int n);
		logic [31:0] s;
		s = '0;
		for (int k = 1; k < n; k++) begin
			if (k <= 8) s[k] = r[8 - k];
			else if (k <= 8 + h) s[k] = r[0];
			else if (k - 8 - h <= 7) s[k] = r[k - 8 - h];
		end
		return s;
	endfunction : expect_stream

	// idle wire toggle, captures, result sink, contention watch and timeout
	always @(posedge clk) begin
		float_bit <= ~float_bit;
		cycles <= cycles + 1;
		if (conversion_active) begin
			cap_p <= mux_pos_ch;
			cap_n <= mux_neg_ch;
			cap_cm <= mux_neg_common;
			cap_gnd <= mux_neg_ground;
			busy_cnt <= busy_cnt + 1;
		end else if (busy_cnt != 0) begin
			busy_len <= busy_cnt;
			busy_cnt <= 0;
		end
		if (result_valid && result_ready) pop_q.push_back(result_data);
		if (serial_result_oe && line_drive) check(32'h0, 32'h1);
		if (cycles == TIMEOUT_CYCLES) begin
			errors++;
			finish_test();
		end
	end

	// main sequence
	initial begin
		logic [31:0] got;
		logic [31:0] drv;
		logic [7:0] r;
		logic [2:0] p;
		logic [2:0] n;
		logic cm;
		sys_rst = 1'b1;
		result_ready = 1'b1;
		repeat (8) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		repeat (4) @(posedge clk);
		#1;
		// abort in mid-conversion: nothing buffered, everything cleared
		ctl.run(5'h18, 0, 4, got, drv);
		check(drv, 32'hF);
		check(32'({pop_q.size() == 0, serial_result_oe, conversion_active, mux_enable}), 32'h8);
		// every assignment code, hold lengths zero to two on the last bit
		for (int c = 0; c < 16; c++) begin
			r = expect_conv(4'(c), p, n, cm);
			ctl.run({1'b1, 4'(c)}, c % 3, 26, got, drv);
			check(got, expect_stream(r, c % 3, 26));
			check(drv, 32'h03FF_FFFF);
			check(32'({cap_p, cap_cm, cap_gnd, cm ? 3'h0 : cap_n}), 32'({p, cm, 1'b0, cm ? 3'h0 : n}));
			check(32'(busy_len > 139 && busy_len < 147), 32'h1);
			check(32'({pop_q.size() == 1, serial_result_oe, conversion_active, mux_enable}), 32'h8);
			check(32'(pop_q.pop_front()), 32'(r));
		end
		// stalled sink: 33 results fit, the next start must wait undriven
		result_ready = 1'b0;
		for (int i = 0; i < 34; i++) begin
			r = expect_conv(4'(i), p, n, cm);
			ctl.run({1'b1, 4'(i)}, 0, 9, got, drv);
			if (i < 33) exp_q.push_back(r);
			if (i < 33) check(got, expect_stream(r, 0, 9));
			check(drv, (i < 33) ? 32'h1FF : 32'h0);
		end
		result_ready = 1'b1;
		repeat (40) @(posedge clk);
		#1;
		check(32'(pop_q.size()), 32'h21);
		while (exp_q.size() != 0) check(32'(pop_q.pop_front()), 32'(exp_q.pop_front()));
		finish_test();
	end
endmodule : sams_top_tb_top
